// file: logic/pltm_lamp_if.sv
// carrier between the top and the lamp multiplexer
`timescale 1ns/1ps
interface pltm_lamp_if;
  import pltm_pkg::*;
  pltm_mode_t                 mode;
  logic [SW_W-1:0]            bist;
  logic [SW_W-1:0]            mom;
  logic [SW_W-1:0]            sel_up;
  logic [SW_W-1:0]            sel_dn;
  logic [15:0]                sig_pol;
  logic [LAMPS_PER_GROUP-1:0] disp  [NUM_GROUPS];
  logic [LAMPS_PER_GROUP-1:0] lamps [NUM_GROUPS];
  logic [SW_W-1:0]            host_sw;
  logic [CODE_W-1:0]          code;

  modport src (output mode, bist, mom, sel_up, sel_dn, sig_pol, disp,
               input  lamps, host_sw, code);
  modport mux (input  mode, bist, mom, sel_up, sel_dn, sig_pol, disp,
               output lamps, host_sw, code);
endinterface : pltm_lamp_if

// file: logic/pltm_lamp_mux.sv
// combinational mode multiplexer for panel lamps and the host switch path
`timescale 1ns/1ps
module pltm_lamp_mux (
  pltm_lamp_if.mux l
);
  import pltm_pkg::*;

  logic [LAMPS_PER_GROUP-1:0] swt [NUM_GROUPS];
  logic [CODE_W-1:0]          code_d;

  // ==========================================================================
  // select switch encoder: lowest held switch wins, centre gives zero
  always_comb begin
    code_d = '0;
    for (int i = SW_W - 1; i >= 0; i--) begin
      if (l.sel_dn[i]) begin
        code_d = CODE_W'(2 * i + 2);
      end
      if (l.sel_up[i]) begin
        code_d = CODE_W'(2 * i + 1);
      end
    end
  end
  assign l.code = code_d;

  // ==========================================================================
  // loop-back pattern
  always_comb begin
    for (int g = 0; g < NUM_GROUPS; g++) begin
      swt[g] = '0;
    end
    swt[GRP_BIST_A] = l.bist;
    swt[GRP_BIST_B] = l.bist;
    swt[GRP_MOM_A]  = ~l.mom;
    swt[GRP_MOM_B]  = ~l.mom;
    swt[GRP_UP_A]   = l.sel_up;
    swt[GRP_UP_B]   = l.sel_up;
    swt[GRP_DN_A]   = l.sel_dn;
    swt[GRP_DN_B]   = l.sel_dn;
    swt[GRP_CODE]   = '0;
    swt[GRP_CODE][CODE_LO +: CODE_W] = code_d;
    swt[GRP_CODE][CODE_HI +: CODE_W] = code_d;
  end

  // ==========================================================================
  // per group mode selection, lamp test first
  for (genvar g = 0; g < NUM_GROUPS; g++) begin : g_grp
    wire [LAMPS_PER_GROUP-1:0] norm_w = (g == SIG_GROUP) ? (l.disp[g] ^ l.sig_pol)
                                                         : l.disp[g];
    assign l.lamps[g] = (l.mode == PLTM_LAMP)   ? '1 :
                        (l.mode == PLTM_NORMAL) ? norm_w :
                                                  swt[g];
  end

  // switch data to the host is cut off outside normal and lamp test
  assign l.host_sw = (l.mode == PLTM_NORMAL || l.mode == PLTM_LAMP) ? l.bist : '0;

endmodule : pltm_lamp_mux

// file: logic/pltm_pkg.sv
// shared constants and types for the panel lamp and switch test multiplexer
package pltm_pkg;

  // ==========================================================================
  // panel geometry
  localparam int LAMPS_PER_GROUP = 16;
  localparam int NUM_GROUPS      = 13;
  localparam int SW_W            = 16;
  localparam int CODE_W          = 6;

  // ==========================================================================
  // lamp groups used while the switches are looped back, and the signal group used in normal mode
  localparam int GRP_BIST_A = 1;
  localparam int GRP_BIST_B = 9;
  localparam int GRP_UP_A   = 2;
  localparam int GRP_UP_B   = 10;
  localparam int GRP_MOM_A  = 3;
  localparam int GRP_MOM_B  = 11;
  localparam int GRP_DN_A   = 4;
  localparam int GRP_DN_B   = 12;
  localparam int GRP_CODE   = 5;
  localparam int CODE_LO    = 0;
  localparam int CODE_HI    = 8;
  localparam int SIG_GROUP  = 0;

  // ==========================================================================
  // panel mode selector positions
  typedef enum logic [1:0] {
    PLTM_NORMAL = 2'b00,
    PLTM_LAMP   = 2'b01,
    PLTM_SWTEST = 2'b10
  } pltm_mode_t;

  // ==========================================================================
  // register map, byte addresses
  localparam int          ADDR_W       = 8;
  localparam logic [7:0]  OFS_MODE     = 8'h00;
  localparam logic [7:0]  OFS_SIG_POL  = 8'h04;
  localparam logic [7:0]  OFS_SW_BIST  = 8'h08;
  localparam logic [7:0]  OFS_SEL_CODE = 8'h0C;
  localparam logic [15:0] SIG_POL_RST  = 16'h0000;
  localparam logic [1:0]  RESP_OKAY    = 2'b00;
  localparam logic [1:0]  RESP_SLVERR  = 2'b10;

endpackage : pltm_pkg

// file: logic/pltm_top.sv
// panel lamp and switch test multiplexer with an AXI4-Lite register slave
//
// Added by the designer: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module pltm_top (
  input  wire logic                                         aclk,
  input  wire logic                                         aresetn,
  input  wire logic [pltm_pkg::ADDR_W-1:0]                  s_axi_awaddr,
  input  wire logic                                         s_axi_awvalid,
  output logic                                              s_axi_awready,
  input  wire logic [31:0]                                  s_axi_wdata,
  input  wire logic [3:0]                                   s_axi_wstrb,
  input  wire logic                                         s_axi_wvalid,
  output logic                                              s_axi_wready,
  output logic [1:0]                                        s_axi_bresp,
  output logic                                              s_axi_bvalid,
  input  wire logic                                         s_axi_bready,
  input  wire logic [pltm_pkg::ADDR_W-1:0]                  s_axi_araddr,
  input  wire logic                                         s_axi_arvalid,
  output logic                                              s_axi_arready,
  output logic [31:0]                                       s_axi_rdata,
  output logic [1:0]                                        s_axi_rresp,
  output logic                                              s_axi_rvalid,
  input  wire logic                                         s_axi_rready,
  input  wire logic [1:0]                                   panel_mode_selector,
  input  wire logic [pltm_pkg::SW_W-1:0]                    panel_bistable_sw,
  input  wire logic [pltm_pkg::SW_W-1:0]                    panel_spring_sw,
  input  wire logic [pltm_pkg::SW_W-1:0]                    panel_select_up,
  input  wire logic [pltm_pkg::SW_W-1:0]                    panel_select_down,
  input  wire logic [pltm_pkg::NUM_GROUPS*pltm_pkg::LAMPS_PER_GROUP-1:0] host_display,
  output logic [pltm_pkg::NUM_GROUPS*pltm_pkg::LAMPS_PER_GROUP-1:0]      panel_lamps,
  output logic [pltm_pkg::SW_W-1:0]                         host_switches
);
  import pltm_pkg::*;

  localparam int LG = LAMPS_PER_GROUP;
  localparam int PW = 2 + 4 * SW_W;

  // ==========================================================================
  // panel pin synchronisers
  logic [PW-1:0] pin_m_q;
  logic [PW-1:0] pin_s_q;
  wire  [PW-1:0] pin_raw = {panel_mode_selector, panel_bistable_sw, panel_spring_sw,
                            panel_select_up, panel_select_down};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_m_q <= '0;
      pin_s_q <= '0;
    end else begin
      pin_m_q <= pin_raw;
      pin_s_q <= pin_m_q;
    end
  end

  wire [1:0]      mode_raw = pin_s_q[PW-1 -: 2];
  wire [SW_W-1:0] bist_s   = pin_s_q[4*SW_W-1 -: SW_W];
  wire [SW_W-1:0] mom_s    = pin_s_q[3*SW_W-1 -: SW_W];
  wire [SW_W-1:0] up_s     = pin_s_q[2*SW_W-1 -: SW_W];
  wire [SW_W-1:0] dn_s     = pin_s_q[SW_W-1:0];
  // the unused fourth selector code is treated as switch test, the safe position
  wire pltm_mode_t mode_w  = (mode_raw == PLTM_NORMAL) ? PLTM_NORMAL :
                             (mode_raw == PLTM_LAMP)   ? PLTM_LAMP : PLTM_SWTEST;

  // ==========================================================================
  // multiplexer
  logic [15:0] sig_pol_q;
  pltm_lamp_if lif ();

  assign lif.mode    = mode_w;
  assign lif.bist    = bist_s;
  assign lif.mom     = mom_s;
  assign lif.sel_up  = up_s;
  assign lif.sel_dn  = dn_s;
  assign lif.sig_pol = sig_pol_q;
  for (genvar g = 0; g < NUM_GROUPS; g++) begin : g_map
    assign lif.disp[g] = host_display[g*LG +: LG];
  end

  pltm_lamp_mux u_mux (
    .l (lif.mux)
  );

  logic [NUM_GROUPS*LG-1:0] lamps_d;
  for (genvar g = 0; g < NUM_GROUPS; g++) begin : g_out
    assign lamps_d[g*LG +: LG] = lif.lamps[g];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      panel_lamps   <= '0;
      host_switches <= '0;
    end else begin
      panel_lamps   <= lamps_d;
      host_switches <= lif.host_sw;
    end
  end

  // ==========================================================================
  // AXI4-Lite write channel
  logic                aw_hold_q;
  logic                w_hold_q;
  logic [ADDR_W-1:0]   awaddr_q;
  logic [31:0]         wdata_q;
  logic [3:0]          wstrb_q;

  assign s_axi_awready = !aw_hold_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_hold_q && !s_axi_bvalid;
  wire   aw_fire  = s_axi_awvalid && s_axi_awready;
  wire   w_fire   = s_axi_wvalid && s_axi_wready;
  wire   aw_have  = aw_hold_q || aw_fire;
  wire   w_have   = w_hold_q || w_fire;
  wire   wr_go    = aw_have && w_have;
  wire [ADDR_W-1:0] wa  = aw_hold_q ? awaddr_q : s_axi_awaddr;
  wire [31:0]       wd  = w_hold_q ? wdata_q : s_axi_wdata;
  wire [3:0]        ws  = w_hold_q ? wstrb_q : s_axi_wstrb;
  wire   wr_pol   = wr_go && (wa == OFS_SIG_POL);
  wire [15:0] pol_d = {ws[1] ? wd[15:8] : sig_pol_q[15:8], ws[0] ? wd[7:0] : sig_pol_q[7:0]};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q    <= 1'b0;
      w_hold_q     <= 1'b0;
      awaddr_q     <= '0;
      wdata_q      <= '0;
      wstrb_q      <= '0;
      sig_pol_q    <= SIG_POL_RST;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else begin
      if (aw_fire) awaddr_q <= s_axi_awaddr;
      if (w_fire) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      aw_hold_q <= wr_go ? 1'b0 : aw_have;
      w_hold_q  <= wr_go ? 1'b0 : w_have;
      if (wr_pol) sig_pol_q <= pol_d;
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wa == OFS_SIG_POL) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // AXI4-Lite read channel
  assign s_axi_arready = !s_axi_rvalid;
  wire   ar_fire = s_axi_arvalid && s_axi_arready;
  wire   rd_hit  = (s_axi_araddr == OFS_MODE) || (s_axi_araddr == OFS_SIG_POL) ||
                   (s_axi_araddr == OFS_SW_BIST) || (s_axi_araddr == OFS_SEL_CODE);
  wire [31:0] rd_val = (s_axi_araddr == OFS_MODE)     ? {30'h0000_0000, mode_w} :
                       (s_axi_araddr == OFS_SIG_POL)  ? {16'h0000, sig_pol_q} :
                       (s_axi_araddr == OFS_SW_BIST)  ? {16'h0000, bist_s} :
                       (s_axi_araddr == OFS_SEL_CODE) ? {26'h000_0000, lif.code} :
                                                        32'h0000_0000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (ar_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_val;
      s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ==========================================================================
  // assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // mode seen one edge earlier, the mode that the registered outputs show now
  pltm_mode_t mode_prev_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_prev_q <= PLTM_NORMAL;
    end else begin
      mode_prev_q <= mode_w;
    end
  end

  wire sw_was = (mode_prev_q == PLTM_SWTEST);
  wire nm_was = (mode_prev_q == PLTM_NORMAL);

  a_host_blocked: assert property (sw_was |-> host_switches == '0)
    else $error("switch data reached host in switch test");
  a_lamp_all_on: assert property ($past(mode_w) == PLTM_LAMP |-> &panel_lamps)
    else $error("lamp test left a lamp dark");
  a_unused_dark: assert property (sw_was |-> panel_lamps[8*LG +: LG] == '0)
    else $error("unused group lit in switch test");
  a_code_twice: assert property (sw_was |->
      panel_lamps[GRP_CODE*LG + CODE_HI +: CODE_W] ==
      panel_lamps[GRP_CODE*LG + CODE_LO +: CODE_W])
    else $error("select code halves differ");
  a_bist_lamp: assert property (sw_was |-> panel_lamps[GRP_BIST_A*LG +: LG] == $past(bist_s))
    else $error("bistable lamp mismatch");
  a_spring_lamp: assert property (sw_was |-> panel_lamps[GRP_MOM_A*LG +: LG] == ~$past(mom_s))
    else $error("spring switch lamp mismatch");
  a_pair_match: assert property (sw_was |->
      panel_lamps[GRP_BIST_A*LG +: LG] == panel_lamps[GRP_BIST_B*LG +: LG])
    else $error("paired lamps disagree");
  a_centre_none: assert property (sw_was && $past(up_s) == '0 && $past(dn_s) == '0
      |-> panel_lamps[GRP_CODE*LG +: LG] == '0)
    else $error("code shown with select switches centred");
  a_first_up: assert property (sw_was && $past(up_s[0])
      |-> panel_lamps[GRP_CODE*LG +: CODE_W] == 6'h01)
    else $error("wrong code for first select switch up");
  a_reg_lamp: assert property (nm_was |->
      panel_lamps[GRP_BIST_A*LG +: LG] == $past(host_display[GRP_BIST_A*LG +: LG]))
    else $error("register lamp mismatch");
  a_sig_lamp: assert property (nm_was |->
      panel_lamps[SIG_GROUP*LG +: LG] == ($past(host_display[SIG_GROUP*LG +: LG]) ^
      $past(sig_pol_q)))
    else $error("signal lamp polarity mismatch");
  a_host_reopen: assert property (mode_w == PLTM_NORMAL ##1 1'b1
      |-> host_switches == $past(bist_s))
    else $error("host path not restored in normal mode");

  c_lamp:   cover property (mode_w == PLTM_LAMP ##1 &panel_lamps);
  c_swtest: cover property (mode_w == PLTM_SWTEST && up_s != '0);
  c_normal: cover property (mode_w == PLTM_NORMAL && host_switches != '0);
  c_write:  cover property (wr_pol);

endmodule : pltm_top

// file: verif/panel_lamp_switch_test_mux_test.sv
// self-checking bench for the panel lamp and switch test multiplexer
`timescale 1ns/1ps
module panel_lamp_switch_test_mux_test;
  import pltm_pkg::*;
  localparam int LW = NUM_GROUPS * LAMPS_PER_GROUP;
  // ======
  // signals
  logic              aclk = 1'b0;
  logic              aresetn, step;
  logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic              s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic              s_axi_rvalid, s_axi_rready;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0]       s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]        s_axi_wstrb;
  logic [1:0]        s_axi_bresp, s_axi_rresp, panel_mode_selector, rs;
  logic [SW_W-1:0]   panel_bistable_sw, panel_spring_sw, panel_select_up, panel_select_down;
  logic [SW_W-1:0]   host_switches, pol, u_v, d_v;
  logic [LW-1:0]     host_display, panel_lamps;
  int                n_errors = 0;
  int                check_count = 0;

  always #50 aclk = ~aclk;

  pltm_top pltm_top_i (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .panel_mode_selector, .panel_bistable_sw, .panel_spring_sw,
    .panel_select_up, .panel_select_down, .host_display, .panel_lamps, .host_switches
  );
  pltm_host_model pltm_host_model_i (.aclk(aclk), .step(step), .host_display(host_display));

  // ======
  // reference model
  function automatic logic [5:0] sel_code(input logic [SW_W-1:0] u, d);
    logic [5:0] c;
    c = '0;
    for (int i = SW_W - 1; i >= 0; i--) begin
      if (u[i] || d[i]) c = u[i] ? 6'(2 * i + 1) : 6'(2 * i + 2);
    end
    return c;
  endfunction : sel_code

  function automatic logic [LW-1:0] exp_lamps(input logic [1:0] m,
                                              input logic [SW_W-1:0] b, s, u, d);
    logic [LW-1:0] e;
    e = '0;
    if (m == 2'b01) e = '1;
    else if (m == 2'b00) begin
      e = host_display;
      e[SIG_GROUP*16+:16] = host_display[SIG_GROUP*16+:16] ^ pol;
    end else begin
      e[GRP_BIST_A*16+:16] = b;
      e[GRP_BIST_B*16+:16] = b;
      e[GRP_UP_A*16+:16] = u;
      e[GRP_UP_B*16+:16] = u;
      e[GRP_MOM_A*16+:16] = ~s;
      e[GRP_MOM_B*16+:16] = ~s;
      e[GRP_DN_A*16+:16] = d;
      e[GRP_DN_B*16+:16] = d;
      e[GRP_CODE*16+:16] = {2'b00, sel_code(u, d), 2'b00, sel_code(u, d)};
    end
    return e;
  endfunction : exp_lamps

  // ======
  // checking and bus tasks
  task automatic chk(input string nm, input logic [LW-1:0] e, input logic [LW-1:0] g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task tally_and_finish;
    if (n_errors == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : tally_and_finish

  task automatic axi_wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, output logic [1:0] r);
    int k;
    @(posedge aclk);
    r = 2'b11;
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= 4'hF;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
    if (k == 50) begin
      n_errors++;
      tally_and_finish();
    end
  endtask : axi_wr

  task automatic axi_rd(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] r);
    int k;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
    end
    if (k == 50) begin
      n_errors++;
      tally_and_finish();
    end
  endtask : axi_rd

  // drive the panel, let the synchronisers settle, compare both outputs
  task automatic apply(input logic [1:0] m, input logic [SW_W-1:0] b, s, u, d);
    panel_mode_selector <= m;
    panel_bistable_sw   <= b;
    panel_spring_sw     <= s;
    panel_select_up     <= u;
    panel_select_down   <= d;
    step                <= 1'b1;
    @(posedge aclk);
    step <= 1'b0;
    repeat (4) @(posedge aclk);
    @(negedge aclk);
    chk("panel_lamps", exp_lamps(m, b, s, u, d), panel_lamps);
    chk("host_switches", m[1] ? '0 : LW'(b), LW'(host_switches));
    @(posedge aclk);
  endtask : apply

  // ======
  // main sequence
  initial begin
    void'($urandom(39));
    {aresetn, step, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {panel_mode_selector, panel_bistable_sw, panel_spring_sw} = '0;
    {panel_select_up, panel_select_down, u_v, d_v} = '0;
    pol = SIG_POL_RST;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(OFS_SIG_POL, rd, rs);
    chk("sig_pol_reset", {16'h0000, SIG_POL_RST, RESP_OKAY}, {rd, rs});
    pol = 16'($urandom);
    axi_wr(OFS_SIG_POL, {16'($urandom), pol}, rs);
    chk("wr_resp", RESP_OKAY, rs);
    axi_rd(OFS_SIG_POL, rd, rs);
    chk("sig_pol", {16'h0000, pol, RESP_OKAY}, {rd, rs});
    axi_wr(OFS_MODE, 32'hFFFF_FFFF, rs);
    chk("ro_write", RESP_SLVERR, rs);
    axi_rd(8'h10, rd, rs);
    chk("unmapped", {32'h0000_0000, RESP_SLVERR}, {rd, rs});
    for (int m = 0; m < 4; m++) begin
      for (int n = 0; n < 12; n++) begin
        u_v = 16'($urandom) & 16'($urandom) & 16'($urandom);
        d_v = 16'($urandom) & 16'($urandom) & 16'($urandom);
        apply(2'(m), 16'($urandom), 16'($urandom), u_v, d_v);
      end
      axi_rd(OFS_MODE, rd, rs);
      chk("mode_reg", {30'h0000_0000, (m == 3) ? 2'b10 : 2'(m)}, rd);
      axi_rd(OFS_SW_BIST, rd, rs);
      chk("bist_reg", 32'(panel_bistable_sw), rd);
    end
    for (int j = 0; j <= 32; j++) begin
      u_v = (j < 16) ? (16'h0001 << j) | (16'($urandom) << (j + 1)) : '0;
      d_v = (j < 32) ? (16'h0001 << (j % 16)) | (16'($urandom) << (j % 16 + 1)) : '0;
      apply(2'b10, 16'($urandom), 16'($urandom), u_v, d_v);
      axi_rd(OFS_SEL_CODE, rd, rs);
      chk("sel_code", 32'(sel_code(u_v, d_v)), rd);
    end
    tally_and_finish();
  end
endmodule : panel_lamp_switch_test_mux_test

// file: verif/pltm_host_model.sv
// processor side model that supplies the register display word
`timescale 1ns/1ps
module pltm_host_model (
  input  wire logic                                               aclk,
  input  wire logic                                               step,
  output logic [pltm_pkg::NUM_GROUPS*pltm_pkg::LAMPS_PER_GROUP-1:0] host_display
);
  import pltm_pkg::*;
  // ======
  // display word
  initial host_display = '0;
  // a running processor shows fresh data at every step
  always @(posedge aclk) begin
    if (step) begin
      for (int g = 0; g < NUM_GROUPS; g++) host_display[g*16+:16] <= 16'($urandom);
    end
  end
endmodule : pltm_host_model
